// ==== verilog/psw_flags_pkg.sv ====
// What this block does
// - base vector flag bit 15 reads one always
// - fatal acknowledge sets bit 7, blocks both levels
// - non-interrupt exception sets servicing flag bit 6
// - maskable or fatal acknowledge sets bit 5
// - gate copy of bit 5, taken at retire or acknowledge, refuses maskable acknowledgement
// - block instruction sets bit 5, unblock clears
// - bit 5 instruction change acts next instruction
// - saturation overflow sets sticky bit 4
// - plain arithmetic leaves sticky bit alone
// - carry bit 3 follows carry or borrow
package psw_flags_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] psw_addr = 4'h0;
  localparam logic [3:0] ctrl_addr = 4'h4;
  localparam int base_vec_bit = 15;
  localparam int fatal_blk_bit = 7;
  localparam int nonint_srv_bit = 6;
  localparam int mask_blk_bit = 5;
  localparam int clamp_bit = 4;
  localparam int carry_bit = 3;
  localparam logic [31:0] flag_mask = 32'h0000_80f8;
  localparam logic [31:0] unmapped_value = 32'h0000_0000;
  localparam logic mask_blk_reset = 1'b1;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic req_fatal;
    logic req_maskable;
    logic exc_non_intr;
  } exc_req_t;

  typedef struct packed {
    logic retire;
    logic block_intr;
    logic unblock_intr;
    logic sat_overflow;
    logic flag_update;
    logic carry;
  } instr_evt_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_rdat = 3'b010,
    st_done = 3'b100
  } bus_state_t;
endpackage

// ==== verilog/psw_ack_arbiter.sv ====
module psw_ack_arbiter (
  input wire logic i_fatal_block,
  input wire logic i_mask_block,
  input wire psw_flags_pkg::exc_req_t i_req,
  output logic o_ack_fatal,
  output logic o_ack_maskable
);
  import psw_flags_pkg::*;
  // servicing flag deliberately not an input
  assign o_ack_fatal = i_req.req_fatal & ~i_fatal_block;
  assign o_ack_maskable = i_req.req_maskable & ~i_mask_block & ~i_fatal_block
    & ~o_ack_fatal;
endmodule // psw_ack_arbiter

// ==== verilog/guest_status_word_flags.sv ====
module guest_status_word_flags (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire psw_flags_pkg::exc_req_t i_exc,
  input wire psw_flags_pkg::instr_evt_t i_ins,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_ack_fatal,
  output logic o_ack_maskable,
  output logic [31:0] o_status_word
);
  import psw_flags_pkg::*;

  // ==========================================================
  // flag state
  logic fblk_q, srv_q, mblk_q, clamp_q, carry_q;
  logic mblk_eff_q;
  logic fblk_d, srv_d, mblk_d, clamp_d, carry_d, mblk_eff_d;
  logic ack_f, ack_m;
  bus_state_t st_q;
  logic [31:0] rdata_q;

  wire logic [31:0] word = {16'h0000, 1'b1, 7'h00, fblk_q, srv_q, mblk_q, clamp_q, carry_q,
    3'h0};
  wire logic sel_psw = i_avs_address == psw_addr;
  wire logic sel_ctrl = i_avs_address == ctrl_addr;
  wire logic wr_go = i_avs_write & (st_q == st_idle);
  wire logic ld_psw = wr_go & sel_psw & i_avs_byteenable[0];
  wire logic [31:0] wmask = flag_mask & i_avs_writedata;

  psw_ack_arbiter u_arb (
    .i_fatal_block(fblk_q),
    .i_mask_block(mblk_eff_q),
    .i_req(i_exc),
    .o_ack_fatal(ack_f),
    .o_ack_maskable(ack_m)
  );

  // ==========================================================
  // next-state: hardware events outrank the load
  always_comb begin
    fblk_d = ld_psw ? wmask[fatal_blk_bit] : fblk_q;
    srv_d = ld_psw ? wmask[nonint_srv_bit] : srv_q;
    mblk_d = ld_psw ? wmask[mask_blk_bit] : mblk_q;
    clamp_d = ld_psw ? wmask[clamp_bit] : clamp_q;
    carry_d = ld_psw ? wmask[carry_bit] : carry_q;
    if (i_ins.retire && i_ins.block_intr) begin
      mblk_d = 1'b1;
    end else if (i_ins.retire && i_ins.unblock_intr) begin
      mblk_d = 1'b0;
    end
    if (i_ins.retire && i_ins.sat_overflow) begin
      clamp_d = 1'b1;
    end
    // plain arithmetic never touches the clamp flag
    if (i_ins.retire && i_ins.flag_update) begin
      carry_d = i_ins.carry;
    end
    if (ack_f) begin
      fblk_d = 1'b1;
    end
    if (ack_f || ack_m) begin
      mblk_d = 1'b1;
    end
    if (i_exc.exc_non_intr) begin
      srv_d = 1'b1;
    end
    // gate copy follows only at retire or on an acknowledge, so the changing instruction keeps old value
    mblk_eff_d = (i_ins.retire || ack_f || ack_m) ? mblk_d : mblk_eff_q;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fblk_q <= 1'b0;
      srv_q <= 1'b0;
      mblk_q <= mask_blk_reset;
      mblk_eff_q <= mask_blk_reset;
      clamp_q <= 1'b0;
      carry_q <= 1'b0;
    end else begin
      fblk_q <= fblk_d;
      srv_q <= srv_d;
      mblk_q <= mblk_d;
      mblk_eff_q <= mblk_eff_d;
      clamp_q <= clamp_d;
      carry_q <= carry_d;
    end
  end

  // ==========================================================
  // avalon slave: two wait cycles for every access
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= st_idle;
      rdata_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        st_idle: begin
          if (i_avs_read || i_avs_write) begin
            st_q <= st_rdat;
          end
          rdata_q <= sel_psw ? word : (sel_ctrl ? {31'h0, mblk_eff_q} : unmapped_value);
        end
        st_rdat: st_q <= st_done;
        st_done: st_q <= st_idle;
        default: st_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      o_ack_fatal <= 1'b0;
      o_ack_maskable <= 1'b0;
      o_status_word <= 32'h0000_8020;
    end else begin
      o_avs_waitrequest <= ~(st_q == st_rdat);
      o_avs_readdata <= rdata_q;
      o_ack_fatal <= ack_f;
      o_ack_maskable <= ack_m;
      o_status_word <= {16'h0000, 1'b1, 7'h00, fblk_d, srv_d, mblk_d, clamp_d, carry_d, 3'h0};
    end
  end
endmodule // guest_status_word_flags

// ==== tb/psw_flags_checker.sv ====
module psw_flags_checker (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire psw_flags_pkg::exc_req_t i_exc,
  input wire psw_flags_pkg::instr_evt_t i_ins,
  input wire logic i_avs_write,
  input wire logic o_ack_fatal,
  input wire logic o_ack_maskable,
  input wire logic [31:0] o_status_word
);
  import psw_flags_pkg::*;
  // ====
  // checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_base_set: assert property (o_status_word[15]) else $error("base flag low");
  a_fatal_sets: assert property (o_ack_fatal |-> o_status_word[7]) else $error("fatal set");
  a_fatal_gate: assert property (o_ack_fatal |-> !$past(o_status_word[7])) else $error("f gate");
  a_exc_sets: assert property (o_ack_fatal && $past(i_exc.exc_non_intr) |-> o_status_word[6])
    else $error("serv flag");
  a_mask_sets: assert property (o_ack_fatal || o_ack_maskable |-> o_status_word[5])
    else $error("block flag");
  a_mask_cause: assert property (o_ack_maskable |-> $past(i_exc.req_maskable))
    else $error("m cause");
  a_clamp_set: assert property (i_ins.retire && i_ins.sat_overflow |=> o_status_word[4])
    else $error("clamp flag");
  a_carry_copy: assert property (i_ins.retire && i_ins.flag_update && !i_avs_write
    |=> o_status_word[3] == $past(i_ins.carry)) else $error("carry");
  c_fatal: cover property (o_ack_fatal);
  c_mask: cover property (o_ack_maskable);
  c_clamp: cover property (i_ins.retire && i_ins.sat_overflow);
endmodule // psw_flags_checker

bind guest_status_word_flags psw_flags_checker i_chk (.i_clk, .i_reset_n, .i_exc, .i_ins,
  .i_avs_write, .o_ack_fatal, .o_ack_maskable, .o_status_word);

// ==== tb/guest_status_word_flags_tb.sv ====
module guest_status_word_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psw_flags_pkg::*;
  // ====
  // harness
  logic i_clk = 0, i_reset_n = 0, rd = 0, wr = 0, ackf, ackm, wq;
  exc_req_t exc = '0;
  instr_evt_t ins = '0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, sw;
  int num_errors = 0, n_compared = 0, cyc = 0;
  guest_status_word_flags i_guest_status_word_flags (.i_clk, .i_reset_n, .i_exc(exc),
    .i_ins(ins), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
    .o_ack_fatal(ackf), .o_ack_maskable(ackm), .o_status_word(sw));
  initial forever #10 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc > 3000) begin
    num_errors++;
    tally_and_finish();
  end
  task cmp(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // read compares d, write sends d
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge i_clk); while (wq);
    if (!w) cmp(rdat, d);
    rd <= 0;
    wr <= 0;
    @(posedge i_clk);
  endtask
  task ev(input instr_evt_t v, input logic [31:0] e);
    ins <= v;
    @(posedge i_clk);
    ins <= '0;
    #1 cmp(sw, e);
    @(posedge i_clk);
  endtask
  task req(input exc_req_t v, input logic [1:0] e, input logic [31:0] s);
    exc <= v;
    @(posedge i_clk);
    exc <= '0;
    #1 cmp({ackf, ackm}, e);
    cmp(sw, s);
    @(posedge i_clk);
  endtask
  task tally_and_finish();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1;
    bus(0, 4'h0, 32'h8020);
    bus(1, 4'h0, 32'h0);
    bus(0, 4'h0, 32'h8000);
    ev(6'h24, 32'h8010);
    ev(6'h23, 32'h8018);
    ev(6'h22, 32'h8010);
    bus(1, 4'h0, 32'h0);
    ev(6'h20, 32'h8000);
    req(3'h5, 2'h2, 32'h80e0);
    req(3'h4, 2'h0, 32'h80e0);
    req(3'h2, 2'h0, 32'h80e0);
    bus(1, 4'h0, 32'h40);
    ev(6'h20, 32'h8040);
    req(3'h2, 2'h1, 32'h8060);
    bus(1, 4'h0, 32'h0);
    ev(6'h30, 32'h8020);
    bus(0, 4'h4, 32'h1);
    req(3'h2, 2'h0, 32'h8020);
    ev(6'h28, 32'h8000);
    req(3'h2, 2'h1, 32'h8020);
    bus(0, 4'h8, 32'h0);
    tally_and_finish();
  end
endmodule // guest_status_word_flags_tb
